// ### hw/dsp_ext_pkg.sv
// constants and types shared by the extension state and control logic
// Behaviour
// - Three extra high/low accumulator pairs sit beside the base pair, picked by a two-bit field where zero is the base pair.
// - Control bits 31:28, 15 and 6 are reserved, written as zero by software and always read as zero.
// - A vector compare writes the flag field at 27:24 from its lowest bit, one bit per element, leaving higher bits alone.
// - The overflow/underflow flags at 23:16 are set by hardware and by the control write instruction, are sticky, and clear only through that write.
// - A saturating dot-product or multiply-accumulate overflow sets flag 16 to 19 after the destination pair zero to three.
// - Overflow in absolute-value, add, subtract and add-with-carry forms sets flag 20.
// - Overflow in the multiply forms sets flag 21.
// - Overflow in the precision-reducing pack and the left shifts sets flag 22.
// - Overflow in the accumulator word extracts sets flag 23.
// - Each positional extract rewrites the extract fail flag at bit 14, one when the position is below the size and zero otherwise.
// - The add-carry-out operation sets or clears the carry at bit 13, and the add-carry-in operation consumes it.
// - The variable insert takes its field width from the size field at 12:7.
// - The position field at 5:0 serves insert and extract, and the decrementing extracts lower it by the size on completion.
// - The low-to-high copy raises the position field by 32 after copying.
// - Two static bits report the extension present and its revision 2, both one when configured and zero otherwise.
// - With the access enable low, an extension operation or a move on pairs one to three raises a disabled exception, code 26, instead of executing.
package dsp_ext_pkg;

    // ==========================================================
    // control register layout
    localparam int POS_LSB = 0;
    localparam int POS_W = 6;
    localparam int SIZE_LSB = 7;
    localparam int SIZE_W = 6;
    localparam int CARRY_BIT = 13;
    localparam int FAIL_BIT = 14;
    localparam int FLAG_LSB = 16;
    localparam int FLAG_W = 8;
    localparam int CMP_LSB = 24;
    localparam int CMP_W = 4;

    // fixed flag positions within the flag field
    localparam int FLAG_ADD = 4;
    localparam int FLAG_MUL = 5;
    localparam int FLAG_SHIFT = 6;
    localparam int FLAG_EXTR = 7;

    // ==========================================================
    // reset values
    localparam logic [POS_W-1:0] POS_RST = 6'h00;
    localparam logic [SIZE_W-1:0] SIZE_RST = 6'h00;
    localparam logic CARRY_RST = 1'b0;
    localparam logic FAIL_RST = 1'b0;
    localparam logic [FLAG_W-1:0] FLAG_RST = 8'h00;
    localparam logic [CMP_W-1:0] CMP_RST = 4'h0;

    // ==========================================================
    // field mask bits of the control write instruction
    localparam int MASK_W = 6;
    localparam int MASK_POS = 0;
    localparam int MASK_SIZE = 1;
    localparam int MASK_CARRY = 2;
    localparam int MASK_FLAG = 3;
    localparam int MASK_CMP = 4;
    localparam int MASK_FAIL = 5;

    localparam logic [POS_W-1:0] POS_STEP = 6'h20;
    localparam logic [4:0] EXC_DISABLED = 5'h1A;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_CTRL_WRITE,
        OP_CMP,
        OP_DOT_MAC,
        OP_ADD,
        OP_ADD_CARRY_OUT,
        OP_ADD_CARRY_IN,
        OP_MUL,
        OP_PACK_SHIFT,
        OP_EXTRACT_WORD,
        OP_POS_EXTRACT,
        OP_DEC_EXTRACT,
        OP_INSERT,
        OP_LOW_TO_HIGH,
        OP_OTHER
    } op_e;

endpackage

// ### hw/acc_bank.sv
// storage for the base and extra high/low accumulator pairs
`timescale 1ns/1ns
module acc_bank
    import dsp_ext_pkg::*;
#(
    parameter int PAIRS = 4,
    parameter int W = 32
) (
    input wire logic mclk_i, // core clock
    input wire logic arst_n_i, // async reset, low
    input wire logic wr_i, // write one word
    input wire logic wr_hi_i, // 1 high word, 0 low word
    input wire logic [1:0] wr_sel_i, // pair written
    input wire logic [W-1:0] wr_data_i, // write data
    input wire logic copy_i, // copy low into high
    input wire logic [1:0] copy_sel_i, // pair copied
    input wire logic rd_i, // read request
    input wire logic [1:0] rd_sel_i, // pair read
    output logic [W-1:0] hi_o, // read high word
    output logic [W-1:0] lo_o // read low word
);

    if (PAIRS != 4) begin : g_chk
        $error("acc_bank needs four pairs for a two-bit select");
    end

    logic [W-1:0] hi_reg [PAIRS];
    logic [W-1:0] lo_reg [PAIRS];

    // ==========================================================
    // one pair per entry, zero is the base pair
    for (genvar p = 0; p < PAIRS; p++) begin : g_pair
        wire hit_wr = wr_i && (wr_sel_i == 2'(p));
        wire hit_cp = copy_i && (copy_sel_i == 2'(p));
        always_ff @(posedge mclk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                hi_reg[p] <= '0;
                lo_reg[p] <= '0;
            end else begin
                if (hit_cp) begin
                    hi_reg[p] <= lo_reg[p];
                end else if (hit_wr && wr_hi_i) begin
                    hi_reg[p] <= wr_data_i;
                end
                if (hit_wr && !wr_hi_i) begin
                    lo_reg[p] <= wr_data_i;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hi_o <= '0;
            lo_o <= '0;
        end else if (rd_i) begin
            hi_o <= hi_reg[rd_sel_i];
            lo_o <= lo_reg[rd_sel_i];
        end
    end

endmodule

// ### hw/access_gate.sv
// enable check for extension operations and extra accumulator moves
`timescale 1ns/1ns
module access_gate (
    input wire logic enable_i, // extension access enable
    input wire logic op_i, // extension operation offered
    input wire logic move_i, // accumulator move offered
    input wire logic [1:0] move_sel_i, // pair of the move
    output logic op_ok_o, // operation may execute
    output logic move_ok_o, // move may execute
    output logic fault_o // disabled-state exception wanted
);

    // the base pair stays reachable so plain code runs with the enable off
    wire extra_pair = move_sel_i != 2'h0;

    assign op_ok_o = op_i && enable_i;
    assign move_ok_o = move_i && (enable_i || !extra_pair);
    assign fault_o = !enable_i && (op_i || (move_i && extra_pair));

endmodule

// ### hw/dsp_ext_state.sv
// extension control register, accumulator pairs and access gating
`timescale 1ns/1ns
module dsp_ext_state
    import dsp_ext_pkg::*;
#(
    parameter int DATA_W = 32,
    parameter int ACC_PAIRS = 4,
    parameter bit EXT_CONFIGURED = 1'b1
) (
    input wire logic mclk_i, // core clock
    input wire logic arst_n_i, // async reset, low
    input wire logic extension_access_enable_i, // status enable bit
    input wire logic op_valid_i, // extension op issued
    input wire op_e op_code_i, // op class
    input wire logic [1:0] acc_sel_i, // destination pair
    input wire logic ovf_i, // op overflowed/underflowed
    input wire logic [CMP_W-1:0] cmp_flags_i, // compare results
    input wire logic [2:0] elem_cnt_i, // compared elements
    input wire logic carry_i, // carry from add-carry-out
    input wire logic [SIZE_W-1:0] size_i, // extract size
    input wire logic [DATA_W-1:0] wr_data_i, // control write data
    input wire logic [MASK_W-1:0] wr_mask_i, // control write field mask
    input wire logic acc_wr_i, // accumulator move in
    input wire logic acc_wr_hi_i, // move targets high word
    input wire logic [1:0] acc_mv_sel_i, // pair of the move
    input wire logic [DATA_W-1:0] acc_wr_data_i, // move data
    input wire logic acc_rd_i, // accumulator move out
    output logic [DATA_W-1:0] extension_control_register_o, // control register
    output logic [DATA_W-1:0] acc_hi_o, // read high word
    output logic [DATA_W-1:0] acc_lo_o, // read low word
    output logic exc_o, // disabled exception pulse
    output logic [4:0] exc_code_o, // exception cause code
    output logic extension_present_bit_o, // static present
    output logic extension_rev2_present_bit_o // static revision 2
);

    if (DATA_W != 32 || ACC_PAIRS != 4) begin : g_chk
        $error("dsp_ext_state supports 32-bit data and four pairs only");
    end

    // ==========================================================
    // state
    logic [POS_W-1:0] pos_reg;
    logic [SIZE_W-1:0] size_reg;
    logic carry_reg;
    logic fail_reg;
    logic [FLAG_W-1:0] flag_reg;
    logic [CMP_W-1:0] cmp_reg;

    logic [POS_W-1:0] pos_next;
    logic [SIZE_W-1:0] size_next;
    logic carry_next;
    logic fail_next;
    logic [FLAG_W-1:0] flag_next;
    logic [CMP_W-1:0] cmp_next;

    // ==========================================================
    // gating
    wire op_req = op_valid_i && (op_code_i != OP_NONE);
    wire rd_req = acc_rd_i;
    logic op_ok;
    logic wr_ok;
    logic rd_ok;
    logic fault_op;
    logic fault_rd;

    access_gate u_gate_op (
        .enable_i(extension_access_enable_i),
        .op_i(op_req),
        .move_i(acc_wr_i),
        .move_sel_i(acc_mv_sel_i),
        .op_ok_o(op_ok),
        .move_ok_o(wr_ok),
        .fault_o(fault_op)
    );

    access_gate u_gate_rd (
        .enable_i(extension_access_enable_i),
        .op_i(1'b0),
        .move_i(rd_req),
        .move_sel_i(acc_mv_sel_i),
        .op_ok_o(),
        .move_ok_o(rd_ok),
        .fault_o(fault_rd)
    );

    wire fault = fault_op || fault_rd;

    // ==========================================================
    // decode
    wire is_wr = op_ok && (op_code_i == OP_CTRL_WRITE);
    wire is_cmp = op_ok && (op_code_i == OP_CMP);
    wire is_mac = op_ok && (op_code_i == OP_DOT_MAC);
    wire is_add = op_ok && (op_code_i == OP_ADD || op_code_i == OP_ADD_CARRY_IN);
    wire is_cout = op_ok && (op_code_i == OP_ADD_CARRY_OUT);
    wire is_mul = op_ok && (op_code_i == OP_MUL);
    wire is_shift = op_ok && (op_code_i == OP_PACK_SHIFT);
    wire is_extr = op_ok && (op_code_i == OP_EXTRACT_WORD);
    wire is_dec = op_ok && (op_code_i == OP_DEC_EXTRACT);
    wire is_pext = is_dec || (op_ok && op_code_i == OP_POS_EXTRACT);
    wire is_copy = op_ok && (op_code_i == OP_LOW_TO_HIGH);
    wire extract_fail = pos_reg < size_i;

    wire wr_pos = is_wr && wr_mask_i[MASK_POS];
    wire wr_size = is_wr && wr_mask_i[MASK_SIZE];
    wire wr_carry = is_wr && wr_mask_i[MASK_CARRY];
    wire wr_flag = is_wr && wr_mask_i[MASK_FLAG];
    wire wr_cmp = is_wr && wr_mask_i[MASK_CMP];
    wire wr_fail = is_wr && wr_mask_i[MASK_FAIL];

    // ==========================================================
    // next values
    assign pos_next = wr_pos ? wr_data_i[POS_LSB +: POS_W] :
        (is_dec && !extract_fail) ? pos_reg - size_i :
        is_copy ? pos_reg + POS_STEP :
        pos_reg;

    // software is the only writer; the insert datapath reads it from the output
    assign size_next = wr_size ? wr_data_i[SIZE_LSB +: SIZE_W] : size_reg;

    // carry-in ops leave the bit for the next chained add
    assign carry_next = wr_carry ? wr_data_i[CARRY_BIT] :
        is_cout ? carry_i :
        carry_reg;

    assign fail_next = wr_fail ? wr_data_i[FAIL_BIT] :
        is_pext ? extract_fail :
        fail_reg;

    wire [FLAG_W-1:0] flag_set;
    wire [3:0] mac_bit = 4'h1 << acc_sel_i;
    assign flag_set[3:0] = (is_mac && ovf_i) ? mac_bit : 4'h0;
    assign flag_set[FLAG_ADD] = is_add && ovf_i;
    assign flag_set[FLAG_MUL] = is_mul && ovf_i;
    assign flag_set[FLAG_SHIFT] = is_shift && ovf_i;
    assign flag_set[FLAG_EXTR] = is_extr && ovf_i;

    // a flag raised in the clearing cycle survives the clear
    wire [FLAG_W-1:0] flag_base = wr_flag ? wr_data_i[FLAG_LSB +: FLAG_W] : flag_reg;
    assign flag_next = flag_base | flag_set;

    for (genvar i = 0; i < CMP_W; i++) begin : g_cmp
        wire take = is_cmp && (3'(i) < elem_cnt_i);
        assign cmp_next[i] = wr_cmp ? wr_data_i[CMP_LSB + i] :
            take ? cmp_flags_i[i] :
            cmp_reg[i];
    end

    // ==========================================================
    // registers
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pos_reg <= POS_RST;
            size_reg <= SIZE_RST;
            carry_reg <= CARRY_RST;
            fail_reg <= FAIL_RST;
            flag_reg <= FLAG_RST;
            cmp_reg <= CMP_RST;
        end else begin
            pos_reg <= pos_next;
            size_reg <= size_next;
            carry_reg <= carry_next;
            fail_reg <= fail_next;
            flag_reg <= flag_next;
            cmp_reg <= cmp_next;
        end
    end

    // reserved bits are constant zero
    wire [DATA_W-1:0] ctrl_next = {4'h0, cmp_next, flag_next, 1'b0, fail_next,
        carry_next, size_next, 1'b0, pos_next};

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            extension_control_register_o <= '0;
            exc_o <= 1'b0;
            exc_code_o <= 5'h00;
            extension_present_bit_o <= EXT_CONFIGURED;
            extension_rev2_present_bit_o <= EXT_CONFIGURED;
        end else begin
            extension_control_register_o <= ctrl_next;
            exc_o <= fault;
            exc_code_o <= fault ? EXC_DISABLED : 5'h00;
            extension_present_bit_o <= EXT_CONFIGURED;
            extension_rev2_present_bit_o <= EXT_CONFIGURED;
        end
    end

    // ==========================================================
    // accumulators
    acc_bank #(
        .PAIRS(ACC_PAIRS),
        .W(DATA_W)
    ) u_acc (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .wr_i(wr_ok),
        .wr_hi_i(acc_wr_hi_i),
        .wr_sel_i(acc_mv_sel_i),
        .wr_data_i(acc_wr_data_i),
        .copy_i(is_copy),
        .copy_sel_i(acc_sel_i),
        .rd_i(rd_ok),
        .rd_sel_i(acc_mv_sel_i),
        .hi_o(acc_hi_o),
        .lo_o(acc_lo_o)
    );

    // ==========================================================
    // checks
    wire [DATA_W-1:0] ctrl = extension_control_register_o;

    sequence s_disabled_req;
        op_req && !extension_access_enable_i;
    endsequence

    sequence s_exc_raised;
        exc_o && exc_code_o == EXC_DISABLED;
    endsequence

    property p_disabled_trap;
        @(posedge mclk_i) disable iff (!arst_n_i)
        s_disabled_req |=> s_exc_raised and (ctrl == $past(ctrl));
    endproperty

    disabled_trap_a: assert property (p_disabled_trap)
        else $error("disabled operation did not trap or changed state");

    reserved_zero_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        ctrl[31:28] == 4'h0 && !ctrl[15] && !ctrl[6])
        else $error("reserved control bits not zero");

    flag_sticky_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !wr_flag |=> (ctrl[23:16] & $past(ctrl[23:16])) == $past(ctrl[23:16]))
        else $error("overflow flag fell without a write");

    mac_flag_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        is_mac && ovf_i |=> ctrl[FLAG_LSB + $past(acc_sel_i)])
        else $error("accumulator overflow flag not set");

    add_flag_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        is_add && ovf_i |=> ctrl[FLAG_LSB + FLAG_ADD])
        else $error("add overflow flag not set");

    fail_flag_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        is_pext |=> ctrl[FAIL_BIT] == $past(extract_fail))
        else $error("extract fail flag wrong");

    dec_pos_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        is_dec && !extract_fail |=> pos_reg == $past(pos_reg) - $past(size_i))
        else $error("decrementing extract position wrong");

    copy_pos_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        is_copy |=> pos_reg == $past(pos_reg) + POS_STEP)
        else $error("copy did not advance position by 32");

    carry_out_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        is_cout |=> ctrl[CARRY_BIT] == $past(carry_i))
        else $error("carry bit not taken from add");

    cmp_keep_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        is_cmp && elem_cnt_i == 3'h2 |=> cmp_reg == {$past(cmp_reg[3:2]), $past(cmp_flags_i[1:0])})
        else $error("compare flags written wrongly");

endmodule

// ### verif/pipe_issuer.sv
// model of the integer pipeline that issues extension operations and moves
`timescale 1ns/1ns
module pipe_issuer
    import dsp_ext_pkg::*;
(
    input wire logic mclk_i, // core clock
    output logic en_o = 1'b0, // access enable
    output logic op_valid_o = 1'b0, // op issued
    output op_e op_code_o = OP_NONE, // op class
    output logic [1:0] sel_o = 2'h0, // destination pair
    output logic ovf_o = 1'b0, // overflow seen
    output logic [CMP_W-1:0] cmp_o = 4'h0, // compare results
    output logic [2:0] cnt_o = 3'h0, // element count
    output logic carry_o = 1'b0, // produced carry
    output logic [SIZE_W-1:0] size_o = 6'h00, // extract size
    output logic [31:0] wdata_o = 32'h0, // control write data
    output logic [MASK_W-1:0] wmask_o = 6'h00, // write field mask
    output logic mv_wr_o = 1'b0, // move in
    output logic mv_hi_o = 1'b0, // move high word
    output logic [1:0] mv_sel_o = 2'h0, // move pair
    output logic [31:0] mv_data_o = 32'h0, // move data
    output logic mv_rd_o = 1'b0 // move out
);
    // ==========================================================
    // requests change only just after an edge and last one cycle
    // the enable moves on an edge of its own so no pending request straddles it
    task automatic set_en(input logic v);
        @(posedge mclk_i);
        en_o <= v;
        op_valid_o <= 1'b0;
        mv_wr_o <= 1'b0;
        mv_rd_o <= 1'b0;
    endtask

    task automatic issue(input op_e c, input logic [1:0] sel, input logic ovf,
        input logic [5:0] sz, input logic [31:0] wd, input logic [5:0] wm, input logic [7:0] aux);
        @(posedge mclk_i);
        op_valid_o <= 1'b1;
        op_code_o <= c;
        sel_o <= sel;
        ovf_o <= ovf;
        size_o <= sz;
        wdata_o <= wd;
        wmask_o <= wm;
        {carry_o, cnt_o, cmp_o} <= aux;
        mv_wr_o <= 1'b0;
        mv_rd_o <= 1'b0;
        mv_data_o <= $urandom;
    endtask

    // qualifiers of an absent op carry junk, never the last value
    task automatic mv(input logic wr, input logic hi, input logic [1:0] sel,
        input logic [31:0] d, input logic rd);
        @(posedge mclk_i);
        op_valid_o <= 1'b0;
        op_code_o <= op_e'($urandom_range(14));
        sel_o <= 2'($urandom);
        ovf_o <= 1'($urandom);
        size_o <= 6'($urandom);
        wdata_o <= $urandom;
        wmask_o <= 6'($urandom);
        {carry_o, cnt_o, cmp_o} <= 8'($urandom);
        mv_wr_o <= wr;
        mv_hi_o <= hi;
        mv_sel_o <= sel;
        mv_data_o <= wr ? d : $urandom;
        mv_rd_o <= rd;
    endtask
endmodule

// ### verif/tb_dsp_ext_state.sv
// self-checking bench for the extension state and control block
`timescale 1ns/1ns
module tb_dsp_ext_state;
    import dsp_ext_pkg::*;
    typedef struct {int due; int kind; logic [31:0] exp;} note_s;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic en_w, vld_w, ovf_w, carry_w, mwr_w, mhi_w, mrd_w, exc_w, pres_w, rev2_w;
    op_e code_w;
    logic [1:0] sel_w, msel_w;
    logic [3:0] cmp_w;
    logic [2:0] cnt_w;
    logic [5:0] size_w, mask_w;
    logic [4:0] exc_code_w;
    logic [31:0] wd_w, md_w, ctl_w, hi_w, lo_w;
    note_s notes[$];
    int ncyc = 0;
    int n_fail = 0;
    int tests_run = 0;
    logic [3:0] cmp_m = 4'h0;
    logic [7:0] flg_m = 8'h00;
    logic fail_m = 1'b0;
    logic carry_m = 1'b0;
    logic [5:0] size_m = 6'h00;
    logic [5:0] pos_m = 6'h00;
    logic [31:0] acc_m[4][2];
    op_e fl_ops[9] = '{OP_DOT_MAC, OP_DOT_MAC, OP_DOT_MAC, OP_DOT_MAC, OP_ADD,
        OP_ADD_CARRY_IN, OP_MUL, OP_PACK_SHIFT, OP_EXTRACT_WORD};

    always #10 mclk_i = ~mclk_i;

    pipe_issuer pipe_issuer_inst (.mclk_i(mclk_i), .en_o(en_w), .op_valid_o(vld_w),
        .op_code_o(code_w), .sel_o(sel_w), .ovf_o(ovf_w), .cmp_o(cmp_w), .cnt_o(cnt_w),
        .carry_o(carry_w), .size_o(size_w), .wdata_o(wd_w), .wmask_o(mask_w),
        .mv_wr_o(mwr_w), .mv_hi_o(mhi_w), .mv_sel_o(msel_w), .mv_data_o(md_w),
        .mv_rd_o(mrd_w));

    dsp_ext_state dsp_ext_state_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .extension_access_enable_i(en_w), .op_valid_i(vld_w), .op_code_i(code_w),
        .acc_sel_i(sel_w), .ovf_i(ovf_w), .cmp_flags_i(cmp_w), .elem_cnt_i(cnt_w),
        .carry_i(carry_w), .size_i(size_w), .wr_data_i(wd_w), .wr_mask_i(mask_w),
        .acc_wr_i(mwr_w), .acc_wr_hi_i(mhi_w), .acc_mv_sel_i(msel_w),
        .acc_wr_data_i(md_w), .acc_rd_i(mrd_w), .extension_control_register_o(ctl_w),
        .acc_hi_o(hi_w), .acc_lo_o(lo_w), .exc_o(exc_w), .exc_code_o(exc_code_w),
        .extension_present_bit_o(pres_w), .extension_rev2_present_bit_o(rev2_w));

    // ==========================================================
    // comparison and expectation bookkeeping
    function automatic logic [31:0] ctl_exp();
        return {4'h0, cmp_m, flg_m, 1'b0, fail_m, carry_m, size_m, 1'b0, pos_m};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // every answer lands one edge after the request edge
    task automatic note(input int kind, input logic [31:0] exp);
        notes.push_back('{ncyc + 2, kind, exp});
    endtask

    always @(negedge mclk_i) begin
        ncyc = ncyc + 1;
        while (notes.size() > 0 && notes[0].due == ncyc) begin
            case (notes[0].kind)
                0: check(ctl_w, notes[0].exp);
                1: check(lo_w, notes[0].exp);
                2: check(hi_w, notes[0].exp);
                default: check({26'h0, exc_w, exc_code_w}, notes[0].exp);
            endcase
            void'(notes.pop_front());
        end
    end

    // ==========================================================
    // stimulus tasks that also advance the reference state
    task automatic op(input op_e c, input logic [1:0] sel, input logic ovf,
        input logic [5:0] sz, input logic [31:0] wd, input logic [5:0] wm, input logic [7:0] aux);
        int b;
        pipe_issuer_inst.issue(c, sel, ovf, sz, wd, wm, aux);
        b = -1;
        if (en_w === 1'b1) begin
            case (c)
                OP_CTRL_WRITE: begin
                    if (wm[MASK_POS]) pos_m = wd[5:0];
                    if (wm[MASK_SIZE]) size_m = wd[12:7];
                    if (wm[MASK_CARRY]) carry_m = wd[13];
                    if (wm[MASK_FLAG]) flg_m = wd[23:16];
                    if (wm[MASK_CMP]) cmp_m = wd[27:24];
                    if (wm[MASK_FAIL]) fail_m = wd[14];
                end
                OP_CMP: for (int i = 0; i < 4; i++) if (i < aux[6:4]) cmp_m[i] = aux[i];
                OP_DOT_MAC: b = sel;
                OP_ADD, OP_ADD_CARRY_IN: b = 4;
                OP_MUL: b = 5;
                OP_PACK_SHIFT: b = 6;
                OP_EXTRACT_WORD: b = 7;
                OP_ADD_CARRY_OUT: carry_m = aux[7];
                OP_POS_EXTRACT, OP_DEC_EXTRACT: begin
                    fail_m = pos_m < sz;
                    if (c == OP_DEC_EXTRACT && !fail_m) pos_m = pos_m - sz;
                end
                OP_LOW_TO_HIGH: begin
                    acc_m[sel][1] = acc_m[sel][0];
                    pos_m = pos_m + 6'h20;
                end
                default: ;
            endcase
            if (ovf && b >= 0) flg_m[b] = 1'b1;
        end
        note(0, ctl_exp());
        note(3, en_w === 1'b1 ? 32'h0 : 32'h3A);
    endtask

    task automatic mv(input logic wr, input logic hi, input logic [1:0] sel, input logic rd);
        logic ok;
        logic [31:0] d;
        d = $urandom;
        pipe_issuer_inst.mv(wr, hi, sel, d, rd);
        // enable as the design will sample it with this move
        ok = en_w === 1'b1 || sel == 2'h0;
        if (rd && ok) note(1, acc_m[sel][0]);
        if (rd && ok) note(2, acc_m[sel][1]);
        if (wr && ok) acc_m[sel][hi] = d;
        note(3, ok ? 32'h0 : 32'h3A);
    endtask

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(83));
        for (int p = 0; p < 4; p++) acc_m[p] = '{32'h0, 32'h0};
        repeat (12) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        @(negedge mclk_i);
        check(ctl_w, 32'h0);
        check({30'h0, pres_w, rev2_w}, 32'h3);
        pipe_issuer_inst.set_en(1'b1);
        op(OP_CTRL_WRITE, 2'h0, 1'b0, 6'h00, 32'hFFFFFFFF, 6'h3F, 8'h00);
        op(OP_CTRL_WRITE, 2'h0, 1'b0, 6'h00, 32'h0, 6'h3F, 8'h00);
        op(OP_CMP, 2'h1, 1'b1, 6'h00, 32'h0, 6'h00, 8'h00);
        op(OP_ADD_CARRY_OUT, 2'h2, 1'b1, 6'h00, 32'h0, 6'h00, 8'h80);
        op(OP_ADD_CARRY_IN, 2'h0, 1'b0, 6'h00, 32'h0, 6'h00, 8'h00);
        for (int i = 0; i < 9; i++) op(fl_ops[i], 2'(i), 1'b1, 6'h00, 32'h0, 6'h00, 8'h00);
        op(OP_ADD, 2'h0, 1'b0, 6'h00, 32'h0, 6'h00, 8'h00);
        op(OP_CTRL_WRITE, 2'h0, 1'b0, 6'h00, 32'h00EF0000, 6'h08, 8'h00);
        op(OP_ADD_CARRY_OUT, 2'h0, 1'b0, 6'h00, 32'h0, 6'h00, 8'h00);
        for (int i = 0; i < 20; i++) begin
            op(OP_CMP, 2'h0, 1'($urandom), 6'h00, 32'h0, 6'h00,
                {1'b0, 3'($urandom_range(4)), 4'($urandom)});
            op(OP_CTRL_WRITE, 2'h0, 1'b0, 6'h00, $urandom, 6'($urandom), 8'h00);
        end
        op(OP_CTRL_WRITE, 2'h0, 1'b0, 6'h00, 32'h0000000A, 6'h01, 8'h00);
        op(OP_DEC_EXTRACT, 2'h0, 1'b0, 6'h0A, 32'h0, 6'h00, 8'h00);
        op(OP_POS_EXTRACT, 2'h0, 1'b0, 6'h01, 32'h0, 6'h00, 8'h00);
        for (int i = 0; i < 16; i++) begin
            op(OP_CTRL_WRITE, 2'h0, 1'b0, 6'h00, $urandom, 6'h03, 8'h00);
            op(i[0] ? OP_DEC_EXTRACT : OP_POS_EXTRACT, 2'h0, 1'b0, 6'($urandom), 32'h0,
                6'h00, 8'h00);
            op(OP_INSERT, 2'h0, 1'b0, 6'h00, 32'h0, 6'h00, 8'h00);
        end
        for (int p = 0; p < 8; p++) mv(1'b1, p[2], 2'(p), 1'b0);
        mv(1'b1, 1'b0, 2'h3, 1'b1);
        for (int p = 0; p < 4; p++) mv(1'b0, 1'b0, 2'(p), 1'b1);
        op(OP_LOW_TO_HIGH, 2'h2, 1'b0, 6'h00, 32'h0, 6'h00, 8'h00);
        mv(1'b0, 1'b0, 2'h2, 1'b1);
        pipe_issuer_inst.set_en(1'b0);
        op(OP_ADD, 2'h0, 1'b1, 6'h00, 32'h0, 6'h00, 8'h00);
        op(OP_LOW_TO_HIGH, 2'h1, 1'b0, 6'h00, 32'h0, 6'h00, 8'h00);
        mv(1'b1, 1'b0, 2'h2, 1'b0);
        mv(1'b0, 1'b0, 2'h1, 1'b1);
        mv(1'b1, 1'b1, 2'h0, 1'b1);
        pipe_issuer_inst.set_en(1'b1);
        mv(1'b0, 1'b0, 2'h2, 1'b1);
        mv(1'b0, 1'b0, 2'h1, 1'b1);
        mv(1'b0, 1'b0, 2'h0, 1'b0);
        for (int i = 0; i < 10 && notes.size() > 0; i++) @(posedge mclk_i);
        if (notes.size() > 0) n_fail++;
        stop_test();
    end
endmodule
